// *** verilog/scd_clock_divider.sv ***
// system clock divider configuration with ahb-lite register access
// ----------------------------------------
// Functional notes
// - core divider field divides the source clock for core, bus and flash.
// - core divider bits 31..28, code N divides by N+1, up to 16.
// - reset loads core divider with 0; the third edge after release loads 0, 1, 3 or 7 from boot option bits.
// - divider register bits 27..19 and 15..0 read as zero.
// - bus/flash clock divides the already divided core clock.
// - bus divider bits 18..16, code N divides by N+1, up to 8.
// - reset loads bus divider with divide-by-two code.
// - flash info bits 31..28 read as zero.
// - flash info bits 27..24 report a fixed flash size code.
// - divider writes ignored in very low power run mode.
// - size code 0011 is 32 KB, 0101 is 64 KB; others reserved.
// ----------------------------------------
module scd_clock_divider
   import scd_pkg::*;
#(
   parameter logic [3:0] FLASH_SIZE_CODE = SCD_FLASH_SIZE_64K
) (
   input wire logic clk_sys, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic clk_src, // source clock to divide, sampled
   input wire logic [1:0] low_power_boot_option, // from flash_option_byte, sampled
   input wire logic very_low_power_run, // power mode, sampled
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write
   input wire logic [2:0] hsize, // size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic hresp, // response
   output logic [31:0] hrdata, // read data
   output logic [3:0] core_clock_divider, // current core code
   output logic [2:0] bus_flash_clock_divider, // current bus code
   output logic clk_core_en, // core clock tick
   output logic clk_bus_en // bus/flash clock tick
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [3:0] boot_code(input logic [1:0] sel);
      unique case (sel)
         2'h0: boot_code = SCD_CORE_DIV1;
         2'h1: boot_code = SCD_CORE_DIV2;
         2'h2: boot_code = SCD_CORE_DIV4;
         default: boot_code = SCD_CORE_DIV8;
      endcase
   endfunction

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [3:0] sync1_q, sync1_d, sync2_q, sync2_d;
   logic src_prev_q, src_prev_d;
   always_comb begin
      sync1_d = {clk_src, very_low_power_run, low_power_boot_option};
      sync2_d = sync1_q;
      src_prev_d = sync2_q[3];
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
         src_prev_q <= 1'b0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         src_prev_q <= src_prev_d;
      end
   end
   logic src_tick, lowpwr_run_s;
   logic [1:0] boot_s;
   assign src_tick = sync2_q[3] & ~src_prev_q;
   assign lowpwr_run_s = sync2_q[2];
   assign boot_s = sync2_q[1:0];

   // ----------------------------------------
   // ahb-lite slave
   // ----------------------------------------
   logic wr_pend_q, wr_pend_d, rd_pend_q, rd_pend_d;
   logic [11:0] addr_q, addr_d;
   // both sync flops reset to zero, so the boot option is trusted only on the third edge after release
   logic [1:0] boot_cnt_q, boot_cnt_d;
   logic boot_load, boot_done, div_wr;
   logic [3:0] core_q, core_d;
   logic [2:0] bus_q, bus_d;
   logic [31:0] rdata_q, rdata_d;
   logic take;
   assign take = hsel & hready & (htrans == HTRANS_NONSEQ);
   assign boot_load = (boot_cnt_q == SCD_BOOT_LOAD_CNT);
   assign boot_done = (boot_cnt_q == SCD_BOOT_DONE_CNT);
   assign div_wr = wr_pend_q & (addr_q == SCD_DIV_CFG_OFS) & ~lowpwr_run_s;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;
   assign core_clock_divider = core_q;
   assign bus_flash_clock_divider = bus_q;

   always_comb begin
      wr_pend_d = take & hwrite;
      rd_pend_d = take & ~hwrite;
      addr_d = take ? haddr[11:0] : addr_q;
      boot_cnt_d = boot_done ? boot_cnt_q : boot_cnt_q + 2'h1;
      core_d = core_q;
      bus_d = bus_q;
      rdata_d = 32'h0000_0000;
      if (boot_load) begin
         core_d = boot_code(boot_s);
      end
      // reserved bits dropped
      // a write landing with the boot load wins: software asked last
      if (div_wr) begin
         core_d = hwdata[SCD_CORE_DIV_MSB:SCD_CORE_DIV_LSB];
         bus_d = hwdata[SCD_BUS_DIV_MSB:SCD_BUS_DIV_LSB];
      end
      if (take && !hwrite) begin
         if (haddr[11:0] == SCD_DIV_CFG_OFS) begin
            rdata_d[SCD_CORE_DIV_MSB:SCD_CORE_DIV_LSB] = core_d;
            rdata_d[SCD_BUS_DIV_MSB:SCD_BUS_DIV_LSB] = bus_d;
         end
         if (haddr[11:0] == SCD_FLASH_INFO_OFS) begin
            rdata_d[SCD_FLASH_SIZE_MSB:SCD_FLASH_SIZE_LSB] = FLASH_SIZE_CODE;
         end
      end else if (rd_pend_q) begin
         rdata_d = rdata_q;
      end
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= 12'h000;
         boot_cnt_q <= 2'h0;
         core_q <= SCD_CORE_DIV1;
         bus_q <= SCD_BUS_DIV_RST;
         rdata_q <= 32'h0000_0000;
      end else begin
         wr_pend_q <= wr_pend_d;
         rd_pend_q <= rd_pend_d;
         addr_q <= addr_d;
         boot_cnt_q <= boot_cnt_d;
         core_q <= core_d;
         bus_q <= bus_d;
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------
   // cascaded dividers
   // ----------------------------------------
   logic [3:0] core_cnt_q, core_cnt_d;
   logic [2:0] bus_cnt_q, bus_cnt_d;
   logic core_en_q, core_en_d, bus_en_q, bus_en_d;
   always_comb begin
      core_cnt_d = core_cnt_q;
      bus_cnt_d = bus_cnt_q;
      core_en_d = 1'b0;
      bus_en_d = 1'b0;
      if (src_tick) begin
         if (core_cnt_q >= core_q) begin
            core_cnt_d = 4'h0;
            core_en_d = 1'b1;
            if (bus_cnt_q >= bus_q) begin
               bus_cnt_d = 3'h0;
               bus_en_d = 1'b1;
            end else begin
               bus_cnt_d = bus_cnt_q + 3'h1;
            end
         end else begin
            core_cnt_d = core_cnt_q + 4'h1;
         end
      end
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         core_cnt_q <= 4'h0;
         bus_cnt_q <= 3'h0;
         core_en_q <= 1'b0;
         bus_en_q <= 1'b0;
      end else begin
         core_cnt_q <= core_cnt_d;
         bus_cnt_q <= bus_cnt_d;
         core_en_q <= core_en_d;
         bus_en_q <= bus_en_d;
      end
   end
   assign clk_core_en = core_en_q;
   assign clk_bus_en = bus_en_q;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   // ratio checkers count ticks on their own, apart from the divider counters
   logic [3:0] chk_core_ticks_q, chk_core_ticks_d;
   logic [2:0] chk_bus_ticks_q, chk_bus_ticks_d;
   logic chk_core_steady_q, chk_core_steady_d, chk_bus_steady_q, chk_bus_steady_d;
   always_comb begin
      chk_core_ticks_d = chk_core_ticks_q;
      chk_bus_ticks_d = chk_bus_ticks_q;
      chk_core_steady_d = chk_core_steady_q;
      chk_bus_steady_d = chk_bus_steady_q;
      if (src_tick) begin
         chk_core_ticks_d = core_en_d ? 4'h0 : chk_core_ticks_q + 4'h1;
      end
      if (core_en_d) begin
         chk_bus_ticks_d = bus_en_d ? 3'h0 : chk_bus_ticks_q + 3'h1;
         chk_core_steady_d = 1'b1;
      end
      if (bus_en_d) begin
         chk_bus_steady_d = 1'b1;
      end
      // a period that saw a code change may be cut short, so it is not judged
      if (core_d != core_q) begin
         chk_core_steady_d = 1'b0;
      end
      if (bus_d != bus_q) begin
         chk_bus_steady_d = 1'b0;
      end
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         chk_core_ticks_q <= 4'h0;
         chk_bus_ticks_q <= 3'h0;
         chk_core_steady_q <= 1'b1;
         chk_bus_steady_q <= 1'b1;
      end else begin
         chk_core_ticks_q <= chk_core_ticks_d;
         chk_bus_ticks_q <= chk_bus_ticks_d;
         chk_core_steady_q <= chk_core_steady_d;
         chk_bus_steady_q <= chk_bus_steady_d;
      end
   end

   // address phases of the two-step bus transfers
   sequence s_div_write_addr;
      hsel && hready && htrans == HTRANS_NONSEQ && hwrite && haddr[11:0] == SCD_DIV_CFG_OFS;
   endsequence
   sequence s_info_write_addr;
      hsel && hready && htrans == HTRANS_NONSEQ && hwrite && haddr[11:0] == SCD_FLASH_INFO_OFS;
   endsequence
   sequence s_div_read_addr;
      hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && haddr[11:0] == SCD_DIV_CFG_OFS;
   endsequence
   sequence s_other_read_addr;
      hsel && hready && htrans == HTRANS_NONSEQ && !hwrite
      && haddr[11:0] != SCD_DIV_CFG_OFS && haddr[11:0] != SCD_FLASH_INFO_OFS;
   endsequence
   // data phases, seen through the synchronised power mode
   sequence s_data_open;
      !lowpwr_run_s;
   endsequence
   sequence s_data_blocked;
      lowpwr_run_s && !boot_load;
   endsequence

   property p_div_reserved_zero;
      @(posedge clk_sys) disable iff (!nrst)
         rd_pend_q && addr_q == SCD_DIV_CFG_OFS |-> hrdata[27:19] == 9'h000 && hrdata[15:0] == 16'h0000;
   endproperty
   a_div_reserved_zero: assert property (p_div_reserved_zero) else $error("divider reserved bits not zero");
   property p_flash_info;
      @(posedge clk_sys) disable iff (!nrst)
         rd_pend_q && addr_q == SCD_FLASH_INFO_OFS |-> hrdata == {4'h0, FLASH_SIZE_CODE, 24'h000000};
   endproperty
   a_flash_info: assert property (p_flash_info) else $error("flash info read wrong");
   property p_lowpwr_block;
      @(posedge clk_sys) disable iff (!nrst)
         s_div_write_addr ##1 s_data_blocked |=> $stable(core_q) && $stable(bus_q);
   endproperty
   a_lowpwr_block: assert property (p_lowpwr_block) else $error("divider written in low power run");
   property p_write_takes;
      @(posedge clk_sys) disable iff (!nrst)
         s_div_write_addr ##1 s_data_open
         |=> core_q == $past(hwdata[SCD_CORE_DIV_MSB:SCD_CORE_DIV_LSB])
         && bus_q == $past(hwdata[SCD_BUS_DIV_MSB:SCD_BUS_DIV_LSB]);
   endproperty
   a_write_takes: assert property (p_write_takes) else $error("divider write lost");
   property p_info_write_ignored;
      @(posedge clk_sys) disable iff (!nrst)
         s_info_write_addr ##1 !boot_load |=> $stable(core_q) && $stable(bus_q);
   endproperty
   a_info_write_ignored: assert property (p_info_write_ignored) else $error("flash info write changed divider");
   property p_div_read_value;
      @(posedge clk_sys) disable iff (!nrst)
         s_div_read_addr
         |=> hrdata[SCD_CORE_DIV_MSB:SCD_CORE_DIV_LSB] == core_q && hrdata[SCD_BUS_DIV_MSB:SCD_BUS_DIV_LSB] == bus_q;
   endproperty
   a_div_read_value: assert property (p_div_read_value) else $error("divider read value wrong");
   property p_other_read_zero;
      @(posedge clk_sys) disable iff (!nrst)
         s_other_read_addr |=> hrdata == 32'h0000_0000;
   endproperty
   a_other_read_zero: assert property (p_other_read_zero) else $error("unmapped read not zero");
   property p_div_hold;
      @(posedge clk_sys) disable iff (!nrst)
         !boot_load && !div_wr |=> $stable(core_q) && $stable(bus_q);
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("divider changed without a write");
   property p_boot_load;
      @(posedge clk_sys) disable iff (!nrst)
         boot_load && !div_wr |=> core_q == boot_code($past(boot_s));
   endproperty
   a_boot_load: assert property (p_boot_load) else $error("boot divider not loaded");
   property p_bus_reset;
      @(posedge clk_sys) disable iff (!nrst)
         boot_cnt_q == 2'h0 |-> bus_q == SCD_BUS_DIV_RST && core_q == SCD_CORE_DIV1;
   endproperty
   a_bus_reset: assert property (p_bus_reset) else $error("bus divider reset wrong");
   property p_cascade;
      @(posedge clk_sys) disable iff (!nrst)
         clk_bus_en |-> clk_core_en;
   endproperty
   a_cascade: assert property (p_cascade) else $error("bus tick without core tick");
   property p_core_pulse_single;
      @(posedge clk_sys) disable iff (!nrst)
         clk_core_en |=> !clk_core_en;
   endproperty
   a_core_pulse_single: assert property (p_core_pulse_single) else $error("core tick longer than a cycle");
   property p_core_ratio;
      @(posedge clk_sys) disable iff (!nrst)
         src_tick && chk_core_steady_q |-> core_en_d == (chk_core_ticks_q == core_q);
   endproperty
   a_core_ratio: assert property (p_core_ratio) else $error("core tick spacing wrong");
   property p_bus_ratio;
      @(posedge clk_sys) disable iff (!nrst)
         core_en_d && chk_bus_steady_q |-> bus_en_d == (chk_bus_ticks_q == bus_q);
   endproperty
   a_bus_ratio: assert property (p_bus_ratio) else $error("bus tick spacing wrong");
   property p_size_fixed;
      @(posedge clk_sys) disable iff (!nrst)
         rd_pend_q && addr_q == SCD_FLASH_INFO_OFS |-> hrdata[27:24] == FLASH_SIZE_CODE;
   endproperty
   a_size_fixed: assert property (p_size_fixed) else $error("size code changed");
endmodule

// *** verilog/scd_pkg.sv ***
// constants for the system clock divider configuration block
package scd_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [11:0] SCD_DIV_CFG_OFS = 12'h000;
   localparam logic [11:0] SCD_FLASH_INFO_OFS = 12'h004;
   // ----------------------------------------
   // field layout
   // ----------------------------------------
   localparam int SCD_CORE_DIV_MSB = 31;
   localparam int SCD_CORE_DIV_LSB = 28;
   localparam int SCD_BUS_DIV_MSB = 18;
   localparam int SCD_BUS_DIV_LSB = 16;
   localparam int SCD_FLASH_SIZE_MSB = 27;
   localparam int SCD_FLASH_SIZE_LSB = 24;
   // ----------------------------------------
   // reset values and codes
   // ----------------------------------------
   localparam logic [3:0] SCD_CORE_DIV1 = 4'h0;
   localparam logic [3:0] SCD_CORE_DIV2 = 4'h1;
   localparam logic [3:0] SCD_CORE_DIV4 = 4'h3;
   localparam logic [3:0] SCD_CORE_DIV8 = 4'h7;
   localparam logic [2:0] SCD_BUS_DIV_RST = 3'h1;
   localparam logic [3:0] SCD_FLASH_SIZE_32K = 4'h3;
   localparam logic [3:0] SCD_FLASH_SIZE_64K = 4'h5;
   // post-reset edge counts for the boot option load
   localparam logic [1:0] SCD_BOOT_LOAD_CNT = 2'h2;
   localparam logic [1:0] SCD_BOOT_DONE_CNT = 2'h3;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// *** testbench/testbench.sv ***
// self-checking bench for the clock divider configuration block
module testbench
   import scd_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // stimulus and design
   // ----------------------------------------
   localparam logic [3:0] PFS = SCD_FLASH_SIZE_32K;
   logic clk_sys = 1'b0, nrst = 1'b0, clk_src = 1'b0, very_low_power_run = 1'b0;
   logic [1:0] low_power_boot_option = 2'h0, src_cnt = 2'h0, htrans = 2'h0;
   logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, clk_core_en, clk_bus_en;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
   logic [2:0] hsize = 3'h2, bus_flash_clock_divider;
   logic [3:0] core_clock_divider;
   logic [3:0] boot_code [4] = '{SCD_CORE_DIV1, SCD_CORE_DIV2, SCD_CORE_DIV4, SCD_CORE_DIV8};
   int fails = 0, checked = 0, g;
   always #20 clk_sys = ~clk_sys;
   // source clock at a quarter of clk_sys, well below the sync limit
   always @(posedge clk_sys) begin
      src_cnt <= src_cnt + 2'h1;
      if (src_cnt[0]) clk_src <= ~clk_src;
   end
   scd_clock_divider #(.FLASH_SIZE_CODE(PFS)) u_dut (.clk_sys(clk_sys), .nrst(nrst), .clk_src(clk_src),
      .low_power_boot_option(low_power_boot_option), .very_low_power_run(very_low_power_run),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .core_clock_divider(core_clock_divider), .bus_flash_clock_divider(bus_flash_clock_divider),
      .clk_core_en(clk_core_en), .clk_bus_en(clk_bus_en));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {20'h0, a};
      hwrite <= wr;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      ahb(1'b1, a, d, rdv);
   endtask
   task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0, rdv);
      check(name, exp, rdv);
   endtask
   task automatic do_reset(input logic [1:0] b);
      nrst <= 1'b0;
      low_power_boot_option <= b;
      repeat (3) @(posedge clk_sys);
      check("core_in_reset", {28'h0, SCD_CORE_DIV1}, {28'h0, core_clock_divider});
      nrst <= 1'b1;
      repeat (3) @(posedge clk_sys);
   endtask
   // cycles between two successive pulses of the chosen enable
   task automatic gap(input bit bus, output int n);
      n = 0;
      do begin
         @(posedge clk_sys);
         n = n + 1;
      end while ((bus ? clk_bus_en : clk_core_en) !== 1'b1 && n < 2000);
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while ((bus ? clk_bus_en : clk_core_en) !== 1'b1 && n < 2000);
      if (bus) check("core_with_bus", 32'h1, {31'h0, clk_core_en});
   endtask
   task automatic end_of_test;
      if (fails == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      for (int b = 0; b < 4; b++) begin
         do_reset(b[1:0]);
         rd_chk("div_reset", SCD_DIV_CFG_OFS, {boot_code[b], 9'h0, SCD_BUS_DIV_RST, 16'h0});
      end
      for (int c = 0; c < 16; c++) begin
         wr(SCD_DIV_CFG_OFS, {c[3:0], 9'h1FF, c[2:0], 16'hFFFF});
         rd_chk("div_rw", SCD_DIV_CFG_OFS, {c[3:0], 9'h0, c[2:0], 16'h0});
         check("core_port", {28'h0, c[3:0]}, {28'h0, core_clock_divider});
         check("bus_port", {29'h0, c[2:0]}, {29'h0, bus_flash_clock_divider});
      end
      wr(SCD_FLASH_INFO_OFS, 32'hFFFFFFFF);
      check("hresp", 32'h0, {31'h0, hresp});
      check("hreadyout", 32'h1, {31'h0, hreadyout});
      rd_chk("flash_info", SCD_FLASH_INFO_OFS, {4'h0, PFS, 24'h0});
      rd_chk("unmapped", 12'h008, 32'h0);
      wr(SCD_DIV_CFG_OFS, 32'h20010000);
      very_low_power_run <= 1'b1;
      repeat (4) @(posedge clk_sys);
      wr(SCD_DIV_CFG_OFS, 32'h50030000);
      rd_chk("div_lowpower", SCD_DIV_CFG_OFS, 32'h20010000);
      very_low_power_run <= 1'b0;
      repeat (4) @(posedge clk_sys);
      // spacing of the enables for a few code pairs, cascaded ratio on the bus side
      for (int k = 0; k < 3; k++) begin
         automatic logic [3:0] c = (k == 0) ? 4'h0 : (k == 1) ? 4'h2 : 4'hF;
         automatic logic [2:0] b = (k == 0) ? 3'h0 : (k == 1) ? 3'h1 : 3'h7;
         wr(SCD_DIV_CFG_OFS, {c, 9'h0, b, 16'h0});
         gap(1'b0, g);
         gap(1'b0, g);
         check("core_gap", 4 * (c + 1), g);
         gap(1'b1, g);
         gap(1'b1, g);
         check("bus_gap", 4 * (c + 1) * (b + 1), g);
      end
      end_of_test;
   end
   initial begin
      #(40 * 30000);
      fails++;
      end_of_test;
   end
endmodule
